// >>> design/core_pkg.sv
// shared constants and carrier types for the fetch/execute core
package core_pkg;
	// widths
	localparam int INSTR_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int DADDR_W = 8;
	localparam int PHASE_CNT = 4;
	// program space sizes, per variant
	localparam logic [PC_W-1:0] PROG_MASK_SMALL = 13'h01ff;
	localparam logic [PC_W-1:0] PROG_MASK_LARGE = 13'h07ff;
	localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
	// register offsets (bank 0 or bank 1 address; mirrored ones also at +80h)
	localparam logic [DADDR_W-1:0] ADDR_INDIRECT = 8'h00;
	localparam logic [DADDR_W-1:0] ADDR_TIMER = 8'h01;
	localparam logic [DADDR_W-1:0] ADDR_PCL = 8'h02;
	localparam logic [DADDR_W-1:0] ADDR_FLAGS = 8'h03;
	localparam logic [DADDR_W-1:0] ADDR_POINTER = 8'h04;
	localparam logic [DADDR_W-1:0] ADDR_PIN_A = 8'h05;
	localparam logic [DADDR_W-1:0] ADDR_PIN_B = 8'h06;
	localparam logic [DADDR_W-1:0] ADDR_PCH_LATCH = 8'h0a;
	localparam logic [DADDR_W-1:0] ADDR_INT_CTRL = 8'h0b;
	localparam logic [DADDR_W-1:0] ADDR_PRESCALER = 8'h81;
	localparam logic [DADDR_W-1:0] ADDR_DIR_A = 8'h85;
	localparam logic [DADDR_W-1:0] ADDR_DIR_B = 8'h86;
	localparam logic [DADDR_W-1:0] ADDR_POWER = 8'h8e;
	localparam logic [DADDR_W-1:0] BANK_STRIDE = 8'h80;
	// regions
	localparam logic [6:0] SFR_TOP = 7'h1f;
	localparam logic [DADDR_W-1:0] GPR0_LO = 8'h20;
	localparam logic [DADDR_W-1:0] GPR0_HI_SMALL = 8'h6f;
	localparam logic [DADDR_W-1:0] GPR0_HI_LARGE = 8'h7f;
	localparam logic [DADDR_W-1:0] GPR1_LO = 8'ha0;
	localparam logic [DADDR_W-1:0] GPR1_HI = 8'hbf;
	// flag register fields
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_BANK = 5;
	// reset values
	localparam logic [DATA_W-1:0] FLAGS_RST = 8'h18;
	localparam logic [DATA_W-1:0] PRESCALER_RST = 8'hff;
	localparam logic [DATA_W-1:0] DIR_RST = 8'hff;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	// one-hot phase codes
	typedef enum logic [3:0] {
		PH_FIRST = 4'b0001,
		PH_SECOND = 4'b0010,
		PH_THIRD = 4'b0100,
		PH_FOURTH = 4'b1000
	} phase_t;
	// alu operation select
	typedef enum logic [3:0] {
		ALU_PASS_B = 4'h0, ALU_ADD = 4'h1, ALU_SUB = 4'h2, ALU_AND = 4'h3,
		ALU_OR = 4'h4, ALU_XOR = 4'h5, ALU_RL = 4'h6, ALU_RR = 4'h7,
		ALU_COM = 4'h8, ALU_INC = 4'h9, ALU_DEC = 4'ha, ALU_SWAP = 4'hb,
		ALU_CLR = 4'hc, ALU_PASS_A = 4'hd
	} alu_op_t;
	// decoded instruction
	typedef struct packed {
		alu_op_t op;
		logic use_lit;
		logic dest_file;
		logic wr_en;
		logic set_c;
		logic set_dc;
		logic set_z;
		logic jump;
		logic call;
		logic ret;
		logic [DATA_W-1:0] lit;
		logic [6:0] faddr;
		logic [2:0] bit_no;
		logic bit_op;
		logic bit_val;
	} decode_t;
	// program memory fetch request
	typedef struct packed {
		logic rd;
		logic [PC_W-1:0] addr;
	} prog_req_t;
endpackage

// >>> design/risc_core.sv
// fetch/execute core, phase sequencer, alu and banked data memory map
`timescale 1ns/1ps
`default_nettype none
module risc_core
	import core_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	output core_pkg::prog_req_t prog_req,
	input wire logic [core_pkg::INSTR_W-1:0] prog_data,
	input wire logic irq,
	output logic [core_pkg::DATA_W-1:0] accum_out,
	output logic [core_pkg::DATA_W-1:0] flags_out,
	output logic [core_pkg::PC_W-1:0] pc_out,
	output logic [core_pkg::DATA_W-1:0] pin_a_out,
	output logic [core_pkg::DATA_W-1:0] pin_b_out,
	output logic [core_pkg::DATA_W-1:0] dir_a_out,
	output logic [core_pkg::DATA_W-1:0] dir_b_out,
	output logic [core_pkg::DATA_W-1:0] prescaler_out,
	output logic [core_pkg::DATA_W-1:0] timer_out,
	output logic phase_fourth
);
	import core_pkg::*;

	// program address wrap for the chosen variant
	localparam logic [PC_W-1:0] PROG_MASK = LARGE_VARIANT ? PROG_MASK_LARGE : PROG_MASK_SMALL;
	localparam int STACK_D = 8;

	phase_t phase_reg; // current quarter of the instruction cycle
	logic [PC_W-1:0] pc_reg; // fetch address
	logic [INSTR_W-1:0] instr_latch; // instruction under execution
	logic exec_valid_reg; // low while a flushed slot passes
	logic [INSTR_W-1:0] fetch_reg; // word captured during fetch
	logic [DATA_W-1:0] accum_reg; // working accumulator, no address
	logic [DATA_W-1:0] flags_reg;
	logic [DATA_W-1:0] pointer_reg;
	logic [DATA_W-1:0] pch_latch_reg;
	logic [DATA_W-1:0] int_ctrl_reg;
	logic [DATA_W-1:0] timer_reg, pin_a_reg, pin_b_reg, dir_a_reg, dir_b_reg, prescaler_reg, power_reg;
	logic [DATA_W-1:0] general_ram [0:255]; // indexed by full bank address
	logic [DATA_W-1:0] operand_reg; // captured in second phase
	logic [PC_W-1:0] stack [0:STACK_D-1];
	logic [2:0] sp_reg;
	logic irq_s1, irq_s2, irq_s3; // pin synchroniser
	logic irq_pend_reg;

	decode_t dec;
	logic [DADDR_W-1:0] eff_addr; // bank/indirect resolved address
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] alu_a, alu_b, alu_y;
	logic alu_c, alu_dc;
	logic [DATA_W-1:0] bit_res;
	logic [DATA_W-1:0] result;
	logic do_write_file;
	logic take_branch;
	logic [PC_W-1:0] branch_target;
	logic [PC_W-1:0] link_addr; // word behind the one executing; pc runs one ahead of it

	// fold mirrored core registers onto their bank 0 address
	function automatic logic [DADDR_W-1:0] fold(input logic [DADDR_W-1:0] a);
		logic [DADDR_W-1:0] lo;
		lo = {1'b0, a[6:0]};
		if (lo == ADDR_INDIRECT || lo == ADDR_PCL || lo == ADDR_FLAGS || lo == ADDR_POINTER ||
			lo == ADDR_PCH_LATCH || lo == ADDR_INT_CTRL) begin
			fold = lo;
		end else begin
			fold = a;
		end
	endfunction

	// true where general ram is built
	function automatic logic is_ram(input logic [DADDR_W-1:0] a);
		if (a >= GPR0_LO && a <= (LARGE_VARIANT ? GPR0_HI_LARGE : GPR0_HI_SMALL)) begin
			is_ram = 1'b1;
		end else begin
			is_ram = LARGE_VARIANT && a >= GPR1_LO && a <= GPR1_HI;
		end
	endfunction

	// instruction decode: 14-bit word in, control bundle out
	always_comb begin
		logic [13:0] w;
		w = instr_latch;
		dec = '0;
		dec.faddr = w[6:0];
		dec.dest_file = w[7];
		dec.lit = w[7:0];
		dec.bit_no = w[9:7];
		unique case (w[13:12])
			2'b00: begin // byte file ops, accumulator with file
				dec.wr_en = 1'b1;
				dec.set_z = 1'b1;
				unique case (w[11:8])
					4'h0: begin // move accum to file or nop
						dec.op = ALU_PASS_A;
						dec.dest_file = 1'b1;
						dec.wr_en = w[7];
						dec.set_z = 1'b0;
						if (w == 14'h0008) begin
							dec.ret = 1'b1; // plain return
							dec.wr_en = 1'b0;
						end
					end
					4'h1: dec.op = ALU_CLR;
					4'h2: begin dec.op = ALU_SUB; dec.set_c = 1'b1; dec.set_dc = 1'b1; end
					4'h3: dec.op = ALU_DEC;
					4'h4: dec.op = ALU_OR;
					4'h5: dec.op = ALU_AND;
					4'h6: dec.op = ALU_XOR;
					4'h7: begin dec.op = ALU_ADD; dec.set_c = 1'b1; dec.set_dc = 1'b1; end
					4'h8: dec.op = ALU_PASS_B;
					4'h9: dec.op = ALU_COM;
					4'ha: dec.op = ALU_INC;
					4'hb: begin dec.op = ALU_DEC; dec.set_z = 1'b0; end
					4'hc: begin dec.op = ALU_RR; dec.set_z = 1'b0; dec.set_c = 1'b1; end
					4'hd: begin dec.op = ALU_RL; dec.set_z = 1'b0; dec.set_c = 1'b1; end
					4'he: begin dec.op = ALU_SWAP; dec.set_z = 1'b0; end
					4'hf: begin dec.op = ALU_INC; dec.set_z = 1'b0; end
				endcase
			end
			2'b01: begin // bit clear/set on a file register
				dec.bit_op = 1'b1;
				dec.bit_val = w[10];
				dec.dest_file = 1'b1;
				dec.wr_en = ~w[11];
				dec.op = ALU_PASS_B;
			end
			2'b10: begin // call or jump
				dec.jump = 1'b1;
				dec.call = ~w[11];
			end
			2'b11: begin // literal ops into the accumulator
				dec.use_lit = 1'b1;
				dec.dest_file = 1'b0;
				dec.wr_en = 1'b1;
				dec.set_z = 1'b1;
				unique casez (w[11:8])
					4'b00??: begin dec.op = ALU_PASS_B; dec.set_z = 1'b0; end
					4'b01??: begin dec.op = ALU_PASS_B; dec.set_z = 1'b0; dec.ret = 1'b1; end
					4'b1000: dec.op = ALU_OR;
					4'b1001: dec.op = ALU_AND;
					4'b1010: dec.op = ALU_XOR;
					4'b110?: begin dec.op = ALU_SUB; dec.set_c = 1'b1; dec.set_dc = 1'b1; end
					4'b1011, 4'b111?: begin dec.op = ALU_ADD; dec.set_c = 1'b1; dec.set_dc = 1'b1; end
				endcase
			end
		endcase
	end

	// address resolution: bank bit, indirect redirect, mirrors
	always_comb begin
		logic [DADDR_W-1:0] raw;
		raw = {flags_reg[FLAG_BANK], dec.faddr};
		if (dec.faddr == ADDR_INDIRECT[6:0]) begin
			raw = pointer_reg;
		end
		eff_addr = fold(raw);
	end

	// data read mux; the accumulator has no address here
	always_comb begin
		rd_data = ZERO_BYTE;
		if (eff_addr[6:0] <= SFR_TOP) begin
			unique case (eff_addr)
				ADDR_TIMER: rd_data = timer_reg;
				ADDR_PCL: rd_data = link_addr[7:0];
				ADDR_FLAGS: rd_data = flags_reg;
				ADDR_POINTER: rd_data = pointer_reg;
				ADDR_PIN_A: rd_data = pin_a_reg;
				ADDR_PIN_B: rd_data = pin_b_reg;
				ADDR_PCH_LATCH: rd_data = pch_latch_reg;
				ADDR_INT_CTRL: rd_data = int_ctrl_reg;
				ADDR_PRESCALER: rd_data = prescaler_reg;
				ADDR_DIR_A: rd_data = dir_a_reg;
				ADDR_DIR_B: rd_data = dir_b_reg;
				ADDR_POWER: rd_data = power_reg;
				default: rd_data = ZERO_BYTE;
			endcase
		end else if (is_ram(eff_addr)) begin
			rd_data = general_ram[eff_addr];
		end
	end

	// alu, two's complement; carry acts as not-borrow on subtract
	always_comb begin
		logic [DATA_W:0] sum;
		logic [4:0] nib;
		alu_a = accum_reg;
		alu_b = dec.use_lit ? dec.lit : operand_reg;
		sum = '0;
		nib = '0;
		alu_c = flags_reg[FLAG_CARRY];
		alu_dc = flags_reg[FLAG_HALF];
		unique case (dec.op)
			ALU_ADD: begin
				sum = {1'b0, alu_b} + {1'b0, alu_a};
				nib = {1'b0, alu_b[3:0]} + {1'b0, alu_a[3:0]};
				alu_y = sum[7:0];
				alu_c = sum[8];
				alu_dc = nib[4];
			end
			ALU_SUB: begin // b minus accumulator
				sum = {1'b0, alu_b} + {1'b0, ~alu_a} + 9'h001;
				nib = {1'b0, alu_b[3:0]} + {1'b0, ~alu_a[3:0]} + 5'h01;
				alu_y = sum[7:0];
				alu_c = sum[8];
				alu_dc = nib[4];
			end
			ALU_AND: alu_y = alu_a & alu_b;
			ALU_OR: alu_y = alu_a | alu_b;
			ALU_XOR: alu_y = alu_a ^ alu_b;
			ALU_RL: begin alu_y = {alu_b[6:0], flags_reg[FLAG_CARRY]}; alu_c = alu_b[7]; end
			ALU_RR: begin alu_y = {flags_reg[FLAG_CARRY], alu_b[7:1]}; alu_c = alu_b[0]; end
			ALU_COM: alu_y = ~alu_b;
			ALU_INC: alu_y = alu_b + 8'h01;
			ALU_DEC: alu_y = alu_b - 8'h01;
			ALU_SWAP: alu_y = {alu_b[3:0], alu_b[7:4]};
			ALU_CLR: alu_y = ZERO_BYTE;
			ALU_PASS_A: alu_y = alu_a;
			default: alu_y = alu_b;
		endcase
	end

	// single bit modify on the operand read back
	always_comb begin
		bit_res = operand_reg;
		bit_res[dec.bit_no] = dec.bit_val;
		result = dec.bit_op ? bit_res : alu_y;
		do_write_file = exec_valid_reg && dec.wr_en && dec.dest_file;
	end

	// branch decision and target; page bits from the high latch
	always_comb begin
		// pc has already stepped past the fetched word, so step back one
		link_addr = (pc_reg - 13'd1) & PROG_MASK;
		take_branch = exec_valid_reg && (dec.jump || dec.ret ||
			(do_write_file && eff_addr == ADDR_PCL));
		if (dec.jump) begin
			branch_target = {pch_latch_reg[4:3], instr_latch[10:0]};
		end else if (dec.ret) begin
			branch_target = stack[sp_reg - 3'd1];
		end else begin
			branch_target = {pch_latch_reg[4:0], result};
		end
	end

	// phase ring: four quarters per instruction cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= PH_FOURTH;
		end else begin
			unique case (phase_reg)
				PH_FIRST: phase_reg <= PH_SECOND;
				PH_SECOND: phase_reg <= PH_THIRD;
				PH_THIRD: phase_reg <= PH_FOURTH;
				PH_FOURTH: phase_reg <= PH_FIRST;
			endcase
		end
	end

	// irq pin: three flops, a high level counts when last two are both high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
			irq_s3 <= 1'b0;
			irq_pend_reg <= 1'b0;
		end else begin
			irq_s1 <= irq;
			irq_s2 <= irq_s1;
			irq_s3 <= irq_s2;
			if (irq_s2 && irq_s3 && int_ctrl_reg[7]) begin
				irq_pend_reg <= 1'b1;
			end else if (phase_reg == PH_FOURTH && irq_pend_reg && !take_branch) begin
				irq_pend_reg <= 1'b0;
			end
		end
	end

	// fetch: pc steps in first phase, word latched in fourth
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_reg <= RESET_VECTOR;
			fetch_reg <= '0;
			instr_latch <= '0;
			exec_valid_reg <= 1'b0;
			sp_reg <= '0;
		end else begin
			if (phase_reg == PH_FIRST) begin
				pc_reg <= (pc_reg + 13'd1) & PROG_MASK;
			end
			if (phase_reg == PH_SECOND) begin
				fetch_reg <= prog_data;
			end
			if (phase_reg == PH_FOURTH) begin
				instr_latch <= fetch_reg;
				exec_valid_reg <= 1'b1;
				if (take_branch) begin
					pc_reg <= branch_target & PROG_MASK;
					exec_valid_reg <= 1'b0;
					if (dec.call) begin
						stack[sp_reg] <= link_addr; // return lands on the flushed word
						sp_reg <= sp_reg + 3'd1;
					end else if (dec.ret) begin
						sp_reg <= sp_reg - 3'd1;
					end
				end else if (irq_pend_reg) begin
					stack[sp_reg] <= link_addr; // flushed word runs after the handler
					sp_reg <= sp_reg + 3'd1;
					pc_reg <= INT_VECTOR;
					exec_valid_reg <= 1'b0;
				end
			end
		end
	end

	// operand read in the second phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			operand_reg <= ZERO_BYTE;
		end else if (phase_reg == PH_SECOND) begin
			operand_reg <= rd_data;
		end
	end

	// accumulator and flags written in the fourth phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			accum_reg <= ZERO_BYTE;
			flags_reg <= FLAGS_RST;
		end else if (phase_reg == PH_FOURTH && exec_valid_reg) begin
			if (dec.wr_en && !dec.dest_file) begin
				accum_reg <= result;
			end
			if (do_write_file && eff_addr == ADDR_FLAGS) begin
				flags_reg <= result;
			end
			if (dec.set_c) begin
				flags_reg[FLAG_CARRY] <= alu_c;
			end
			if (dec.set_dc) begin
				flags_reg[FLAG_HALF] <= alu_dc;
			end
			if (dec.set_z) begin
				flags_reg[FLAG_ZERO] <= (result == ZERO_BYTE);
			end
		end
	end

	// special register and ram writes in the fourth phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pointer_reg <= ZERO_BYTE;
			pch_latch_reg <= ZERO_BYTE;
			int_ctrl_reg <= ZERO_BYTE;
			timer_reg <= ZERO_BYTE;
			pin_a_reg <= ZERO_BYTE;
			pin_b_reg <= ZERO_BYTE;
			dir_a_reg <= DIR_RST;
			dir_b_reg <= DIR_RST;
			prescaler_reg <= PRESCALER_RST;
			power_reg <= ZERO_BYTE;
		end else if (phase_reg == PH_FOURTH && do_write_file) begin
			unique case (eff_addr)
				ADDR_POINTER: pointer_reg <= result;
				ADDR_PCH_LATCH: pch_latch_reg <= result;
				ADDR_INT_CTRL: int_ctrl_reg <= result;
				ADDR_TIMER: timer_reg <= result;
				ADDR_PIN_A: pin_a_reg <= result;
				ADDR_PIN_B: pin_b_reg <= result;
				ADDR_DIR_A: dir_a_reg <= result;
				ADDR_DIR_B: dir_b_reg <= result;
				ADDR_PRESCALER: prescaler_reg <= result;
				ADDR_POWER: power_reg <= result;
				default: begin
					if (is_ram(eff_addr)) begin
						general_ram[eff_addr] <= result;
					end
				end
			endcase
		end
	end

	// outputs registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prog_req <= '0;
			accum_out <= ZERO_BYTE;
			flags_out <= FLAGS_RST;
			pc_out <= RESET_VECTOR;
			pin_a_out <= ZERO_BYTE;
			pin_b_out <= ZERO_BYTE;
			dir_a_out <= DIR_RST;
			dir_b_out <= DIR_RST;
			prescaler_out <= PRESCALER_RST;
			timer_out <= ZERO_BYTE;
			phase_fourth <= 1'b0;
		end else begin
			prog_req.rd <= (phase_reg == PH_FIRST);
			// taken once per cycle so the address stands until the next fetch
			if (phase_reg == PH_FIRST) begin
				prog_req.addr <= pc_reg;
			end
			accum_out <= accum_reg;
			flags_out <= flags_reg;
			pc_out <= pc_reg;
			pin_a_out <= pin_a_reg;
			pin_b_out <= pin_b_reg;
			dir_a_out <= dir_a_reg;
			dir_b_out <= dir_b_reg;
			prescaler_out <= prescaler_reg;
			timer_out <= timer_reg;
			phase_fourth <= (phase_reg == PH_THIRD);
		end
	end
endmodule
`default_nettype wire

// >>> verification/prog_mem_model.sv
// program memory model answering the core's fetch requests
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
	input wire logic clk,
	input wire core_pkg::prog_req_t prog_req,
	output logic [core_pkg::INSTR_W-1:0] prog_data
);
	import core_pkg::*;
	logic [INSTR_W-1:0] mem [0:2047]; // word store, filled by the bench
	logic [INSTR_W-1:0] last_word_reg; // word served at the last fetch
	// the index keeps 11 bits, so high addresses fold back into the store
	always_comb begin
		if (prog_req.rd) begin
			prog_data = mem[prog_req.addr[10:0]];
		end else begin
			// outside a fetch the bus never repeats the old word
			prog_data = ~last_word_reg;
		end
	end
	// remember what was served
	always_ff @(posedge clk) begin
		if (prog_req.rd) begin
			last_word_reg <= mem[prog_req.addr[10:0]];
		end
	end
endmodule
`default_nettype wire

// >>> verification/risc_core_asserts.sv
// port checker for the fetch/execute core
`timescale 1ns/1ps
`default_nettype none
module risc_core_asserts #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire core_pkg::prog_req_t prog_req,
	input wire logic [core_pkg::INSTR_W-1:0] prog_data,
	input wire logic irq,
	input wire logic [core_pkg::DATA_W-1:0] accum_out,
	input wire logic [core_pkg::DATA_W-1:0] flags_out,
	input wire logic [core_pkg::PC_W-1:0] pc_out,
	input wire logic [core_pkg::DATA_W-1:0] pin_a_out,
	input wire logic [core_pkg::DATA_W-1:0] pin_b_out,
	input wire logic [core_pkg::DATA_W-1:0] dir_a_out,
	input wire logic [core_pkg::DATA_W-1:0] dir_b_out,
	input wire logic [core_pkg::DATA_W-1:0] prescaler_out,
	input wire logic [core_pkg::DATA_W-1:0] timer_out,
	input wire logic phase_fourth
);
	import core_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic fetch_seen_reg; // a fetch has gone out since reset
	// marks the first fetch after each reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetch_seen_reg <= 1'b0;
		end else if (prog_req.rd) begin
			fetch_seen_reg <= 1'b1;
		end
	end
	chk_phase_ring: assert property (phase_fourth |=> !phase_fourth [*3] ##1 phase_fourth)
		else $error("fourth phase not one clock in four");
	chk_fetch_spacing: assert property (prog_req.rd |=> !prog_req.rd [*3] ##1 prog_req.rd)
		else $error("fetch not once per instruction cycle");
	chk_fetch_phase: assert property (prog_req.rd |-> ##2 phase_fourth)
		else $error("fetch not two clocks before fourth phase");
	chk_addr_hold: assert property (prog_req.rd |=> $stable(prog_req.addr) [*2])
		else $error("fetch address moved outside first phase");
	chk_reset_vector: assert property ((prog_req.rd && !fetch_seen_reg) |-> prog_req.addr == RESET_VECTOR)
		else $error("first fetch after reset not at vector");
	// results land only at the end of a fourth phase
	chk_accum_timing: assert property ($changed(accum_out) |-> ($past(phase_fourth) || $past(phase_fourth, 2)))
		else $error("accumulator changed outside result write");
	chk_flag_timing: assert property ($changed(flags_out) |-> ($past(phase_fourth) || $past(phase_fourth, 2)))
		else $error("flags changed outside result write");
	chk_port_timing: assert property (($changed(pin_a_out) || $changed(pin_b_out) || $changed(dir_a_out)
		|| $changed(dir_b_out)) |-> ($past(phase_fourth) || $past(phase_fourth, 2)))
		else $error("register changed outside result write");
	cover property (accum_out == ZERO_BYTE && flags_out[FLAG_ZERO]);
	cover property ($rose(flags_out[FLAG_BANK]));
	cover property ($changed(dir_b_out));
	cover property (prog_req.rd && prog_req.addr == INT_VECTOR);
endmodule
bind risc_core risc_core_asserts #(.LARGE_VARIANT(LARGE_VARIANT)) chk_u (.clk(clk), .resetn(resetn),
	.prog_req(prog_req), .prog_data(prog_data), .irq(irq), .accum_out(accum_out), .flags_out(flags_out),
	.pc_out(pc_out), .pin_a_out(pin_a_out), .pin_b_out(pin_b_out), .dir_a_out(dir_a_out),
	.dir_b_out(dir_b_out), .prescaler_out(prescaler_out), .timer_out(timer_out), .phase_fourth(phase_fourth));
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench running small programs on the core
`timescale 1ns/1ps
`default_nettype none
module tb;
	import core_pkg::*;
	typedef logic [INSTR_W-1:0] prog_t [8]; // eight-word program image
	logic clk, resetn, irq; // bench-driven inputs
	prog_req_t prog_req; // fetch request
	logic [INSTR_W-1:0] prog_data; // word from the model
	logic [DATA_W-1:0] accum_out, flags_out, pin_a_out, pin_b_out, dir_a_out, dir_b_out, prescaler_out, timer_out;
	logic [PC_W-1:0] pc_out; // pc copy
	logic phase_fourth; // phase marker
	int bad_count = 0; // mismatches
	int checked = 0; // comparisons
	risc_core #(.LARGE_VARIANT(1'b1)) dut_u (.clk(clk), .resetn(resetn), .prog_req(prog_req),
		.prog_data(prog_data), .irq(irq), .accum_out(accum_out), .flags_out(flags_out), .pc_out(pc_out),
		.pin_a_out(pin_a_out), .pin_b_out(pin_b_out), .dir_a_out(dir_a_out), .dir_b_out(dir_b_out),
		.prescaler_out(prescaler_out), .timer_out(timer_out), .phase_fourth(phase_fourth));
	prog_mem_model pm_u (.clk(clk), .prog_req(prog_req), .prog_data(prog_data));
	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// compare one value against its expectation
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// load a program at 0000h, nops elsewhere, and restart the core
	task automatic boot(input prog_t prog);
		@(negedge clk);
		resetn = 1'b0;
		for (int i = 0; i < 2048; i++) begin
			pm_u.mem[i] = (i < 8) ? prog[i] : 14'h0000;
		end
		repeat (5) @(negedge clk);
		resetn = 1'b1;
	endtask
	// let n instruction cycles pass, bounded so a stuck core cannot hang the run
	task automatic run(input int n);
		int seen;
		seen = 0;
		for (int g = 0; g < 8 * n && seen < n; g++) begin
			@(posedge clk);
			#1;
			if (phase_fourth === 1'b1) begin
				seen++;
			end
		end
		check(16'(seen), 16'(n));
		if (seen < n) begin
			final_report();
		end
		repeat (3) @(negedge clk);
	endtask
	// reset values at the ports
	task automatic s_reset();
		@(negedge clk);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		check(16'(pc_out), 16'(RESET_VECTOR));
		check(16'(flags_out), 16'(FLAGS_RST));
		check(16'({dir_a_out, dir_b_out}), {DIR_RST, DIR_RST});
		check(16'(prescaler_out), 16'(PRESCALER_RST));
		resetn = 1'b1;
	endtask
	// add with full carry out, then a subtraction without borrow
	task automatic s_alu();
		boot('{14'h30ff, 14'h3e01, 0, 0, 0, 0, 0, 0});
		run(6);
		check(16'(accum_out), 16'h0000);
		check(16'(flags_out), 16'h001f);
		boot('{14'h3001, 14'h3c03, 0, 0, 0, 0, 0, 0});
		run(6);
		check(16'(accum_out), 16'h0002);
		check(16'(flags_out), 16'h001b);
	endtask
	// same file offset lands in a different register once bank 1 is selected
	task automatic s_bank();
		boot('{14'h303c, 14'h0085, 14'h1683, 14'h30c3, 14'h0085, 14'h0081, 14'h0803, 0});
		run(9);
		check(16'(pin_a_out), 16'h003c);
		check(16'(dir_a_out), 16'h00c3);
		check(16'(flags_out), 16'h0038);
		check(16'(prescaler_out), 16'h00c3);
		check(16'(accum_out), 16'h0038);
	endtask
	// write through the pointer, then read an unimplemented place
	task automatic s_indirect();
		boot('{14'h3086, 14'h0084, 14'h30a5, 14'h0080, 14'h0807, 0, 0, 0});
		run(9);
		check(16'(dir_b_out), 16'h00a5);
		check(16'(accum_out), 16'h0000);
		check(16'(flags_out), 16'h001c);
	endtask
	// the word after a jump is fetched but must not execute
	task automatic s_jump();
		boot('{14'h305a, 14'h2804, 14'h0085, 0, 14'h3022, 14'h0081, 0, 0});
		run(9);
		check(16'(pin_a_out), 16'h0000);
		check(16'(accum_out), 16'h0022);
		check(16'(timer_out), 16'h0022);
	endtask
	// a call returns to the word that its own flush discarded
	task automatic s_call();
		boot('{14'h2004, 14'h3011, 14'h0085, 14'h2803, 14'h3099, 14'h0008, 0, 0});
		run(9);
		check(16'(pin_a_out), 16'h0011);
		check(16'(accum_out), 16'h0011);
	endtask
	// enabled interrupt leaves a self loop for the vector
	task automatic s_irq();
		boot('{14'h3080, 14'h008b, 14'h2802, 0, 14'h3044, 0, 0, 0});
		run(6);
		check(16'(accum_out), 16'h0080);
		irq = 1'b1;
		run(8);
		irq = 1'b0;
		run(3);
		check(16'(accum_out), 16'h0044);
	endtask
	// main sequence
	initial begin
		resetn = 1'b0;
		irq = 1'b0;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		s_reset();
		s_alu();
		s_bank();
		s_indirect();
		s_jump();
		s_call();
		s_irq();
		final_report();
	end
endmodule
`default_nettype wire
